// *** rtl/paefb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - flag mode select high during master reset selects polled mode.
// - polled mode steps through all four quadrants unless master reset cuts ownership short.
// - each clock edge while owning quadrants one to three loads the next quadrant onto the bus.
// - sync is high for the whole cycle showing the first quadrant only.
// - master owns first, showing quadrant one at third edge after master reset release.
// - owner keeps bus three more cycles; others keep outputs disabled.
// - after last quadrant pass token out; token in takes the bus.
// - each device drives its own sync, only on its own first quadrant.
// - single device loops token back; bus still needs incoming token.
// - quadrant n bits 0..7 show queues 8n to 8n+7 in order.
module paefb_top
  import paefb_pkg::*;
(
  input  wire logic                   CLK_SYS,
  input  wire logic                   RST_N,
  input  wire logic                   MASTER_RESET_N,
  input  wire logic                   FLAG_MODE_SELECT,
  input  wire logic                   MASTER_SELECT,
  input  wire logic                   TOKEN_IN,
  input  wire logic [QUEUE_COUNT-1:0] QUEUE_ALMOST_EMPTY,
  output logic      [QUAD_WIDTH-1:0]  ALMOST_EMPTY_STATUS_BUS_O,
  output logic                        ALMOST_EMPTY_STATUS_BUS_OE,
  output logic                        FLAG_BUS_SYNC,
  output logic                        TOKEN_OUT,
  output logic                        POLLED_MODE
);

  // picks the eight status bits of one quadrant
  function automatic logic [QUAD_WIDTH-1:0] quad_sel(
    input logic [QUEUE_COUNT-1:0] st,
    input logic [1:0]             q
  );
    quad_sel = st[q*QUAD_WIDTH +: QUAD_WIDTH];
  endfunction

  logic [2:0]            pin_sync;
  logic                  mrs_n_s;
  logic                  mode_s;
  logic                  master_s;
  logic                  tok_s;

  paefb_sync #(.WIDTH(3)) u_pin_sync (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .d     ({MASTER_RESET_N, FLAG_MODE_SELECT, MASTER_SELECT}),
    .q     (pin_sync)
  );

  paefb_sync #(.WIDTH(1)) u_tok_sync (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .d     (TOKEN_IN),
    .q     (tok_s)
  );

  assign mrs_n_s  = pin_sync[2];
  assign mode_s   = pin_sync[1];
  assign master_s = pin_sync[0];

  paefb_state_t          state_reg;
  paefb_state_t          state_next;
  logic [1:0]            quad_reg;
  logic [1:0]            quad_next;
  logic [QUAD_WIDTH-1:0] bus_reg;
  logic [QUAD_WIDTH-1:0] bus_next;
  logic                  oe_reg;
  logic                  oe_next;
  logic                  sync_reg;
  logic                  sync_next;
  logic                  tok_reg;
  logic                  tok_next;
  logic                  mode_reg;
  logic                  mode_next;
  logic                  master_reg;
  logic                  master_next;

  always_comb begin
    state_next  = state_reg;
    quad_next   = quad_reg;
    bus_next    = bus_reg;
    oe_next     = 1'b0;
    sync_next   = 1'b0;
    tok_next    = 1'b0;
    mode_next   = mode_reg;
    master_next = master_reg;
    if (!mrs_n_s) begin
      // straps are caught while master reset is held
      mode_next   = mode_s;
      master_next = master_s;
      state_next  = PAEFB_HELD;
      quad_next   = QUAD_FIRST;
    end else begin
      case (state_reg)
        PAEFB_HELD: begin
          if (mode_reg && master_reg) begin
            state_next = PAEFB_OWN;
            quad_next  = QUAD_FIRST;
            bus_next   = quad_sel(QUEUE_ALMOST_EMPTY, QUAD_FIRST);
            oe_next    = 1'b1;
            sync_next  = 1'b1;
          end else begin
            state_next = PAEFB_WAIT;
          end
        end
        PAEFB_WAIT: begin
          if (mode_reg && tok_s) begin
            state_next = PAEFB_OWN;
            quad_next  = QUAD_FIRST;
            bus_next   = quad_sel(QUEUE_ALMOST_EMPTY, QUAD_FIRST);
            oe_next    = 1'b1;
            sync_next  = 1'b1;
          end
        end
        PAEFB_OWN: begin
          if (quad_reg == QUAD_LAST) begin
            state_next = PAEFB_WAIT;
            tok_next   = 1'b1;
          end else begin
            quad_next = quad_reg + 2'h1;
            bus_next  = quad_sel(QUEUE_ALMOST_EMPTY, quad_next);
            oe_next   = 1'b1;
          end
        end
        default: begin
          state_next = PAEFB_HELD;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_reg  <= PAEFB_HELD;
      quad_reg   <= QUAD_FIRST;
      bus_reg    <= BUS_RESET;
      oe_reg     <= 1'b0;
      sync_reg   <= 1'b0;
      tok_reg    <= 1'b0;
      mode_reg   <= 1'b0;
      master_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      quad_reg   <= quad_next;
      bus_reg    <= bus_next;
      oe_reg     <= oe_next;
      sync_reg   <= sync_next;
      tok_reg    <= tok_next;
      mode_reg   <= mode_next;
      master_reg <= master_next;
    end
  end

  assign ALMOST_EMPTY_STATUS_BUS_O  = bus_reg;
  assign ALMOST_EMPTY_STATUS_BUS_OE = oe_reg;
  assign FLAG_BUS_SYNC              = sync_reg;
  assign TOKEN_OUT                  = tok_reg;
  assign POLLED_MODE                = mode_reg;

  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  chk_sync_first_quad: assert property (
    FLAG_BUS_SYNC |-> oe_reg && quad_reg == QUAD_FIRST)
    else $error("sync high without first quadrant");
  chk_sync_only_owner: assert property (
    oe_reg && quad_reg == QUAD_FIRST |-> FLAG_BUS_SYNC)
    else $error("first quadrant shown without sync");
  chk_quad_ascend: assert property (
    oe_reg && quad_reg != QUAD_LAST && mrs_n_s
      |=> oe_reg && quad_reg == $past(quad_reg) + 2'h1)
    else $error("quadrant did not advance by one");
  chk_own_four_cycles: assert property (
    disable iff (!RST_N || !mrs_n_s)
    $rose(oe_reg) |-> oe_reg[*4] ##1 !oe_reg)
    else $error("ownership not exactly four cycles");
  chk_token_after_last: assert property (
    oe_reg && quad_reg == QUAD_LAST && mrs_n_s |=> TOKEN_OUT && !oe_reg)
    else $error("token not passed after last quadrant");
  chk_token_one_pulse: assert property (
    TOKEN_OUT |=> !TOKEN_OUT)
    else $error("token pulse longer than one cycle");
  chk_master_start: assert property (
    state_reg == PAEFB_HELD && mrs_n_s && mode_reg && master_reg
      |=> oe_reg && FLAG_BUS_SYNC)
    else $error("master did not take bus after reset");
  chk_token_take: assert property (
    state_reg == PAEFB_WAIT && mrs_n_s && mode_reg && tok_s
      |=> oe_reg && quad_reg == QUAD_FIRST)
    else $error("incoming token not taken");
  chk_no_token_no_bus: assert property (
    state_reg == PAEFB_WAIT && !tok_s |=> !oe_reg)
    else $error("bus driven without token");
  chk_direct_quiet: assert property (
    !mode_reg |-> !oe_reg && !TOKEN_OUT)
    else $error("bus driven outside polled mode");
  chk_data_map: assert property (
    oe_reg |-> bus_reg == (($past(QUEUE_ALMOST_EMPTY)
      >> (quad_reg * QUAD_WIDTH)) & 32'h0000_00ff))
    else $error("bus does not match quadrant status");
  // ownership is cut short whenever master reset is seen
  chk_abort_on_reset: assert property (
    !mrs_n_s |=> !oe_reg && !FLAG_BUS_SYNC && !TOKEN_OUT)
    else $error("bus kept after master reset");
  chk_sync_one_cycle: assert property (
    FLAG_BUS_SYNC |=> !FLAG_BUS_SYNC)
    else $error("sync high for more than one cycle");
  chk_sync_on_take: assert property (
    $rose(FLAG_BUS_SYNC) |-> $rose(oe_reg))
    else $error("sync raised without taking the bus");
  chk_token_from_last: assert property (
    TOKEN_OUT |-> $past(oe_reg) && $past(quad_reg) == QUAD_LAST)
    else $error("token sent without last quadrant");

endmodule // paefb_top
`default_nettype wire

// *** include/paefb_pkg.sv ***
`default_nettype none
package paefb_pkg;
  localparam int          QUAD_COUNT   = 4;
  localparam int          QUAD_WIDTH   = 8;
  localparam int          QUEUE_COUNT  = QUAD_COUNT * QUAD_WIDTH;
  localparam logic [1:0]  QUAD_FIRST   = 2'h0;
  localparam logic [1:0]  QUAD_LAST    = 2'h3;
  localparam logic [7:0]  BUS_RESET    = 8'h00;
  localparam int          SYNC_STAGES  = 2;
  typedef enum logic [1:0] {PAEFB_HELD, PAEFB_WAIT, PAEFB_OWN} paefb_state_t;
endpackage
`default_nettype wire

// *** rtl/paefb_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module paefb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] out_reg;

  // two-flop synchroniser for pins from outside the clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      out_reg  <= '0;
    end else begin
      meta_reg <= d;
      out_reg  <= meta_reg;
    end
  end

  assign q = out_reg;
endmodule // paefb_sync
`default_nettype wire

// *** verif/paefb_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module paefb_partner (
  input  wire logic       clk,
  input  wire logic [7:0] bus_o,
  input  wire logic       bus_oe,
  input  wire logic       token_out,
  input  wire logic       inject,
  output logic            token_in,
  output logic      [7:0] bus_wire
);
  logic [7:0] last = 8'h00;
  // token ring closed on itself, plus a spare entry for a lone slave
  assign token_in = token_out | inject;
  always @(posedge clk) begin
    if (bus_oe) begin
      last <= bus_o;
    end
  end
  // an undriven bus shows the inverse of its last value
  assign bus_wire = bus_oe ? bus_o : ~last;
endmodule // paefb_partner
`default_nettype wire

// *** verif/paefb_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module paefb_top_tb;
  import paefb_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        mrs_n = 1'b0;
  logic        fm = 1'b1;
  logic        master_select = 1'b1;
  logic        inject = 1'b0;
  logic [31:0] st = 32'h0000_0000;
  wire logic   tok_in, tok_out, oe, sync, pm;
  wire logic [7:0] bo, bw;
  int          n_fail = 0;
  int          n_compared = 0;
  int          w;
  always #2.5 clk = ~clk;
  paefb_top i_dut (.CLK_SYS(clk), .RST_N(rst_n), .MASTER_RESET_N(mrs_n),
    .FLAG_MODE_SELECT(fm), .MASTER_SELECT(master_select), .TOKEN_IN(tok_in),
    .QUEUE_ALMOST_EMPTY(st), .ALMOST_EMPTY_STATUS_BUS_O(bo),
    .ALMOST_EMPTY_STATUS_BUS_OE(oe), .FLAG_BUS_SYNC(sync),
    .TOKEN_OUT(tok_out), .POLLED_MODE(pm));
  paefb_partner i_far (.clk(clk), .bus_o(bo), .bus_oe(oe),
    .token_out(tok_out), .inject(inject), .token_in(tok_in), .bus_wire(bw));
  task stop_test;
    $display("counts: fail %0d compared %0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task boot(input logic f, input logic m);
    mrs_n = 1'b0;
    fm = f;
    master_select = m;
    repeat (5) @(negedge clk);
    mrs_n = 1'b1;
  endtask
  // wait for ownership, then check one full pass of four quadrants
  task own(output int i);
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (oe === 1'b1) break;
      st = $urandom;
    end
    if (i == 20) begin
      n_fail++;
      stop_test;
    end
    for (int n = 0; n < 4; n++) begin
      `CHK("oe", 1'b1, oe)
      `CHK("sync", logic'(n == 0), sync)
      `CHK("bus", st[8*n+:8], bw)
      st = $urandom;
      @(negedge clk);
    end
    `CHK("oe", 1'b0, oe)
    `CHK("token", 1'b1, tok_out)
    `CHK("sync", 1'b0, sync)
  endtask
  initial begin
    void'($urandom(32'h44ea));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    boot(1'b1, 1'b1);
    repeat (2) begin
      @(negedge clk);
      `CHK("early oe", 1'b0, oe)
    end
    own(w);
    `CHK("latency", 0, w)
    `CHK("mode", 1'b1, pm)
    own(w);
    own(w);
    $display("test polled master loop done");
    boot(1'b0, 1'b1);
    repeat (30) begin
      @(negedge clk);
      `CHK("oe", 1'b0, oe)
      `CHK("token", 1'b0, tok_out)
    end
    `CHK("mode", 1'b0, pm)
    $display("test direct mode done");
    boot(1'b1, 1'b0);
    repeat (20) begin
      @(negedge clk);
      `CHK("oe", 1'b0, oe)
    end
    inject = 1'b1;
    @(negedge clk);
    inject = 1'b0;
    own(w);
    own(w);
    $display("test slave token entry done");
    stop_test;
  end
endmodule // paefb_top_tb
`default_nettype wire
